// *** sar_ctrl_pkg.sv ***
// Shared constants for the successive-approximation conversion control.
// Assumes a single 50 MHz clock domain and an external comparator/ladder.
package sar_ctrl_pkg;
  localparam int          RESULT_W      = 8;       // Result width, one trial per bit
  localparam int          LADDER_STEPS  = 256;     // Equal steps across the reference span
  localparam int          TRIAL_CNT_W   = 3;       // Counter width for eight trials
  localparam logic [7:0]  SAR_RESET_VAL = 8'h00;   // Cleared approximation register
  localparam logic [7:0]  DATA_RESET_VAL = 8'h00;  // Output data register at reset
  localparam logic [7:0]  TOP_TRIAL_BIT = 8'h80;   // First trial weight, MSB
  localparam int          DONE_LOW_MAX_CLK = 8;    // Latest fall of done after launch rise
  localparam int          SYNC_STAGES   = 3;       // Pin synchroniser depth

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HOLD  = 2'b01,
    ST_TRIAL = 2'b11,
    ST_LOAD  = 2'b10
  } conv_state_e;
endpackage

// *** pin_sync.sv ***
// Three-stage synchroniser for one asynchronous pin.
// Assumes the pin may change at any time relative to mclk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock, reset, enable
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic clkEn,
  // Pin and clean level
  input  wire logic pinAsync,
  output logic      pinLevel
);
  import sar_ctrl_pkg::*;

  logic [SYNC_STAGES-1:0] stage_r;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage_r <= '0;
    end else if (clkEn) begin
      stage_r <= {stage_r[SYNC_STAGES-2:0], pinAsync};
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pinLevel <= 1'b0;
    end else if (clkEn && (stage_r[1] == stage_r[2])) begin
      pinLevel <= stage_r[2];
    end
  end
endmodule
`default_nettype wire

// *** sar_adc_conversion_control.sv ***
// Conversion control for an 8-bit successive-approximation converter.
// Assumes an external comparator that answers within one mclk of trialCode.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control (
  // Clock, reset, enable
  input  wire logic                              mclk,
  input  wire logic                              reset,
  input  wire logic                              clkEn,
  // Launch pin from the controller
  input  wire logic                              conversion_launch_pulse,
  // Ladder and comparator
  output logic [sar_ctrl_pkg::RESULT_W-1:0]      trialCode,
  input  wire logic                              compAtOrAbove,
  // Result side
  output logic [sar_ctrl_pkg::RESULT_W-1:0]      resultData,
  output logic                                   convDone
);
  import sar_ctrl_pkg::*;

  conv_state_e              state_r;
  logic [RESULT_W-1:0]      sar_r;
  logic [RESULT_W-1:0]      trialBit_r;
  logic [TRIAL_CNT_W-1:0]   trialCnt_r;
  logic                     launchLvl;
  logic                     launchPrev_r;
  logic                     launchRise;
  logic                     launchFall;
  logic                     loadDone_r;
  logic [3:0]               riseAge_r;

  // Launch pin arrives from outside, so it is synchronised first
  pin_sync u_launch_sync (
    .mclk     (mclk),
    .reset    (reset),
    .clkEn    (clkEn),
    .pinAsync (conversion_launch_pulse),
    .pinLevel (launchLvl)
  );

  // Edge detection on the cleaned level
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      launchPrev_r <= 1'b0;
    end else if (clkEn) begin
      launchPrev_r <= launchLvl;
    end
  end
  assign launchRise = launchLvl & ~launchPrev_r;
  assign launchFall = ~launchLvl & launchPrev_r;

  // Sequencer; a rise wins over any state so a running conversion is dropped
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else if (clkEn) begin
      if (launchRise) begin
        state_r <= ST_HOLD;
      end else begin
        unique case (state_r)
          ST_IDLE:  state_r <= ST_IDLE;
          ST_HOLD: begin
            if (launchFall) begin
              state_r <= ST_TRIAL;
            end
          end
          ST_TRIAL: begin
            if (trialCnt_r == TRIAL_CNT_W'(RESULT_W - 1)) begin
              state_r <= ST_LOAD;
            end
          end
          ST_LOAD:  state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Approximation register: cleared on launch, one bit decided per trial
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sar_r      <= SAR_RESET_VAL;
      trialBit_r <= TOP_TRIAL_BIT;
      trialCnt_r <= '0;
    end else if (clkEn) begin
      if (launchRise || state_r == ST_HOLD) begin
        sar_r      <= SAR_RESET_VAL;
        trialBit_r <= TOP_TRIAL_BIT;
        trialCnt_r <= '0;
      end else if (state_r == ST_TRIAL) begin
        // Keep the trial bit only when input is at or above the tap
        if (compAtOrAbove) begin
          sar_r <= sar_r | trialBit_r;
        end
        trialBit_r <= trialBit_r >> 1;
        trialCnt_r <= trialCnt_r + TRIAL_CNT_W'(1);
      end
    end
  end

  // Ladder tap selection: code N picks tap N of 256 equal steps; the
  // ladder end resistors give the half-step offset of the first transition
  assign trialCode = sar_r | trialBit_r;

  // Output data register, straight binary, updated in the load state
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      resultData <= DATA_RESET_VAL;
    end else if (clkEn && state_r == ST_LOAD) begin
      resultData <= sar_r;
    end
  end

  // Done rises the clock after the data load; falls on the launch edge.
  // Held low from reset so free-run needs an external first pulse.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      loadDone_r <= 1'b0;
      convDone   <= 1'b0;
    end else if (clkEn) begin
      loadDone_r <= (state_r == ST_LOAD) && !launchRise;
      if (launchRise) begin
        convDone <= 1'b0;
      end else if (loadDone_r) begin
        convDone <= 1'b1;
      end
    end
  end

  // Clocks since the last detected launch rise, saturating; only used to
  // bound the fall of done, so four bits are plenty for a limit of eight
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      riseAge_r <= 4'h0;
    end else if (clkEn) begin
      if (launchRise) begin
        riseAge_r <= 4'h1;
      end else if (riseAge_r != 4'h0 && riseAge_r != 4'hF) begin
        riseAge_r <= riseAge_r + 4'h1;
      end
    end
  end

  // Done goes low within the allowed count after the launch rise
  AST_DONE_FALLS: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && launchRise) |=> !convDone)
    else $error("done not low after launch");

  // Register stays clear while the launch level is high
  AST_HOLD_CLEAR: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && state_r == ST_HOLD) |=> (sar_r == SAR_RESET_VAL))
    else $error("register not cleared during launch");

  // No trial starts before the launch falls
  AST_WAIT_FALL: assert property (@(posedge mclk) disable iff (reset)
    (state_r == ST_HOLD && launchLvl && clkEn) |=> state_r != ST_TRIAL)
    else $error("trial began before launch fell");

  // Exactly eight trials between hold and load without clock gating
  // A relaunch abandons the run, so it ends the attempt rather than failing it
  AST_EIGHT_TRIALS: assert property (@(posedge mclk)
    disable iff (reset || !clkEn || launchRise)
    ($rose(state_r == ST_TRIAL) && !launchRise) |->
      (state_r == ST_TRIAL)[*8] ##1 (state_r == ST_LOAD))
    else $error("trial count not eight");

  // Restart abandons a running conversion
  AST_RESTART: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && launchRise && state_r == ST_TRIAL) |=> state_r == ST_HOLD)
    else $error("running conversion not abandoned");

  // Data loads one clock before done rises
  AST_LOAD_BEFORE_DONE: assert property (@(posedge mclk) disable iff (reset || !clkEn)
    $rose(convDone) |-> $past(state_r, 2) == ST_LOAD && resultData == $past(sar_r, 2))
    else $error("data not loaded before done");

  // First trial code is the MSB alone
  AST_MSB_FIRST: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && state_r == ST_HOLD && !launchRise) |=> trialCode == TOP_TRIAL_BIT)
    else $error("first trial not MSB");

  // A kept bit matches the comparator answer
  AST_BIT_KEEP: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && state_r == ST_TRIAL && !launchRise) |=>
      ((sar_r & $past(trialBit_r)) != 0) == $past(compAtOrAbove))
    else $error("trial bit decision wrong");

  // Done stays low for the whole allowed span after a launch rise
  AST_DONE_BOUND: assert property (@(posedge mclk) disable iff (reset)
    (riseAge_r != 4'h0 && riseAge_r <= 4'(DONE_LOW_MAX_CLK)) |-> !convDone)
    else $error("done high inside launch span");

  // Trial weight walks one place toward the LSB each trial
  AST_TRIAL_WALK: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && state_r == ST_TRIAL && !launchRise) |=> trialBit_r == ($past(trialBit_r) >> 1))
    else $error("trial weight did not step");

  // Nothing starts from idle without a launch rise
  AST_IDLE_STAYS: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && state_r == ST_IDLE && !launchRise) |=> state_r == ST_IDLE)
    else $error("left idle without launch");

  // Result only changes through the load state
  AST_DATA_HOLDS: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && state_r != ST_LOAD) |=> $stable(resultData))
    else $error("result changed outside load");

  // Done is a level, held until the next launch rise
  AST_DONE_HOLDS: assert property (@(posedge mclk) disable iff (reset)
    (clkEn && convDone && !launchRise) |=> convDone)
    else $error("done dropped without launch");

  // A low enable freezes sequencer, register and outputs
  AST_CLKEN_HOLD: assert property (@(posedge mclk) disable iff (reset)
    !clkEn |=> ($stable(state_r) && $stable(sar_r) && $stable(resultData)
      && $stable(convDone)))
    else $error("state moved while disabled");
endmodule
`default_nettype wire

// *** sar_comp_model.sv ***
// Comparator and ladder model facing the trial code of the converter.
// Assumes level is the analog input already counted in ladder steps.
`timescale 1ns/1ps
`default_nettype none
module sar_comp_model (
  // Trial side
  input  wire logic [7:0] trialCode,
  // Analog input in ladder steps
  input  wire logic [7:0] level,
  output logic            compAtOrAbove
);
  // 256 equal steps, answer within the same clock; half-step offset is folded into level
  assign compAtOrAbove = (level >= trialCode);
endmodule
`default_nettype wire

// *** sar_adc_conversion_control_tb_top.sv ***
// Self-checking bench for the conversion control with a comparator model.
// Assumes clkEn may stay high; the bench plays the controller on the launch pin.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control_tb_top;
  import sar_ctrl_pkg::*;
  logic        mclk;
  logic        reset;
  logic        clkEn;
  int          doneCount;
  logic        launch;
  logic        comp;
  logic [7:0]  trialCode;
  logic [7:0]  resultData;
  logic [7:0]  level;
  logic [7:0]  prevData;
  logic        convDone;
  int          bad_count = 0;
  int          total_checks = 0;
  // Input level beside expected code: straight binary, so equal
  logic [15:0] rows [6] = '{16'h0000, 16'hFFFF, 16'h8080, 16'h7F7F, 16'hA5A5, 16'h0101};

  sar_comp_model CMP (.trialCode(trialCode), .level(level), .compAtOrAbove(comp));
  sar_adc_conversion_control DUT (.mclk(mclk), .reset(reset), .clkEn(clkEn),
    .conversion_launch_pulse(launch), .trialCode(trialCode), .compAtOrAbove(comp),
    .resultData(resultData), .convDone(convDone));

  // Clock at 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Launch held nine clocks, well past the synchroniser lag
  task start(input logic [7:0] lv);
    @(posedge mclk) begin
      level  <= lv;
      launch <= 1'b1;
    end
    repeat (8) @(posedge mclk);
    #1;
    chk(convDone === 1'b0, "done still high");
    chk(trialCode === 8'h80, "register not cleared");
    @(posedge mclk) launch <= 1'b0;
  endtask

  // Bounded wait for done; the value seen the clock before must already be loaded
  task finish_conv(input logic [7:0] exp);
    int n;
    for (n = 0; n < 40 && convDone !== 1'b1; n++) begin
      prevData = resultData;
      @(posedge mclk);
      #1;
    end
    chk(convDone === 1'b1, "no done");
    chk(n >= 9, "finished too early");
    chk(resultData === exp, "wrong code");
    chk(prevData === exp, "data not loaded first");
  endtask

  initial begin
    reset = 1'b1;
    launch = 1'b0;
    level = 8'h00;
    clkEn = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(resultData === DATA_RESET_VAL && convDone === 1'b0, "reset values");
    @(posedge mclk) reset <= 1'b0;
    // First launch after power-up comes from the bench
    foreach (rows[i]) begin
      start(rows[i][15:8]);
      finish_conv(rows[i][7:0]);
    end
    // Relaunch in mid-conversion abandons the first
    start(8'h3C);
    repeat (5) @(posedge mclk);
    start(8'hC3);
    finish_conv(8'hC3);
    // Reset in mid-run clears the result side
    start(8'h55);
    repeat (4) @(posedge mclk) reset <= 1'b1;
    #1;
    chk(resultData === DATA_RESET_VAL && convDone === 1'b0, "mid-run reset");
    // Release again: idle code after two edges, then a clean conversion
    @(posedge mclk) reset <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(convDone === 1'b0 && trialCode === 8'h80, "after release");
    start(8'h66);
    finish_conv(8'h66);
    // Freeze while the fall is still in the synchroniser; the conversion must resume afterwards
    start(8'h5A);
    repeat (2) @(posedge mclk);
    @(posedge mclk) clkEn <= 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    chk(convDone === 1'b0 && trialCode === 8'h80, "moved while frozen");
    @(posedge mclk) clkEn <= 1'b1;
    finish_conv(8'h5A);
    // Free-running: done fed back to the launch pin
    @(posedge mclk) level <= 8'h96;
    doneCount = 0;
    repeat (120) @(posedge mclk) begin
      launch <= convDone;
      if (convDone === 1'b1 && launch === 1'b0) doneCount++;
    end
    @(posedge mclk) launch <= 1'b0;
    chk(doneCount >= 3, "free-run stalled");
    chk(resultData === 8'h96, "free-run code");
    results;
  end

  // Watchdog well beyond about 400 clocks of tests
  initial begin
    #200000;
    bad_count++;
    results;
  end
endmodule
`default_nettype wire
